// [rail_sequencing_phase_config.sv]
// Four-rail sequencing, conduction mode and switching phase configuration.
// Assumes command strobes from a PMBus front end, synchronous to sys_clk.
// Behaviour
// - Gating bit 0 clear holds each start rank until previous rank is good; set ignores power good.
// - First start rank starts without any power-good check.
// - Gating is one global bit 0, default 0; bits 7:1 read zero.
// - Per rail stop rank bits 3:2, start rank bits 1:0, default 00.
// - Rails of equal rank start or stop together.
// - Four rank settings, selected by page 0 to 3.
// - Mode bit 0: 1 continuous conduction (default), 0 mixed; bits 7:2 zero.
// - Mode bit 1 shows current sharing, only on a master page.
// - Sharing per pair; slave page invalid, slave follows master settings.
// - Slave switching runs 180 degrees from its master.
// - Detected sharing sets the master's shared flag.
// - Mode and frequency writes act only after store and reload.
// - Switching clock is oscillator divided by 1, 2, 4 or 8.
// - Phase delay of N quarter oscillator periods, N 0 to 31.
// - Phase defaults 0, 2, 1, 3 for pages 0 to 3.
// - Phase shift equals 90 degrees times delay code over two to the divider code.
// - Enable pin starts sequence; deassertion stops it, even mid-start.
`timescale 1ns/1ns
module rail_sequencing_phase_config
    import rail_seq_pkg::*;
#(
    parameter int NUM_RAILS = 4
)(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       nv_rst,
    input  wire logic       nv_store,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    input  wire logic [7:0] cmd_code,
    input  wire logic [1:0] cmd_page,
    input  wire logic [7:0] cmd_wdata,
    output logic      [7:0] cmd_rdata,
    input  wire logic       first_rail_enable_pin,
    input  wire logic [3:0] rail_power_good,
    input  wire logic [1:0] share_detect,
    output logic      [3:0] rail_on,
    output logic      [3:0] continuous_conduction_select,
    output logic      [3:0] pwm_clk,
    output logic            seq_busy
);
    // =========================================================
    // Storage
    logic                  prior_rail_good_gate_q;
    logic [3:0][3:0]       rank_q;
    logic [3:0]            ccm_img_q;
    logic [3:0][6:0]       freq_img_q;
    logic [3:0]            nv_ccm_q;
    logic [3:0][6:0]       nv_freq_q;
    logic [3:0]            op_ccm_q;
    logic [3:0][6:0]       op_freq_q;
    logic                  load_pend_q;
    logic [4:0]            quarter_q;
    logic [7:0]            rdata_d;

    logic                  page_slave;
    logic                  page_valid;
    logic [3:0]            slave_on;
    logic [3:0][1:0]       eff_start;
    logic [3:0][1:0]       eff_stop;
    logic [3:0][6:0]       eff_freq;
    logic [3:0]            eff_ccm;

    function automatic logic [6:0] freq_default(input int idx);
        freq_default = {PHASE_RST[idx], DIV_RST};
    endfunction

    // Slave page of a sharing pair accepts only the global gating command
    assign page_slave = cmd_page[0] && share_detect[cmd_page[1]];
    assign page_valid = !page_slave;

    // =========================================================
    // Global gating and per-page ranks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prior_rail_good_gate_q <= GATE_RST;
        end else if (cmd_wr && cmd_code == CMD_GATING) begin
            prior_rail_good_gate_q <= cmd_wdata[GATE_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rank_q <= {NUM_RAILS{{RANK_RST, RANK_RST}}};
        end else if (cmd_wr && cmd_code == CMD_RANK && page_valid) begin
            rank_q[cmd_page] <= cmd_wdata[3:0];
        end
    end

    // =========================================================
    // Nonvolatile image, kept over ordinary reset
    always_ff @(posedge sys_clk or posedge nv_rst) begin
        if (nv_rst) begin
            nv_ccm_q <= {NUM_RAILS{CCM_RST}};
            for (int i = 0; i < NUM_RAILS; i++) begin
                nv_freq_q[i] <= freq_default(i);
            end
        end else if (nv_store) begin
            nv_ccm_q  <= ccm_img_q;
            nv_freq_q <= freq_img_q;
        end
    end

    // =========================================================
    // Readable images; reload from the image after reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            load_pend_q <= 1'b1;
        end else begin
            load_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ccm_img_q <= {NUM_RAILS{CCM_RST}};
            for (int i = 0; i < NUM_RAILS; i++) begin
                freq_img_q[i] <= freq_default(i);
            end
        end else if (load_pend_q) begin
            ccm_img_q  <= nv_ccm_q;
            freq_img_q <= nv_freq_q;
        end else if (cmd_wr && page_valid) begin
            if (cmd_code == CMD_MODE) begin
                ccm_img_q[cmd_page] <= cmd_wdata[CCM_BIT];
            end
            if (cmd_code == CMD_FREQ) begin
                freq_img_q[cmd_page] <= cmd_wdata[6:0];
            end
        end
    end

    // Operating copies change only at reload
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_ccm_q <= {NUM_RAILS{CCM_RST}};
            for (int i = 0; i < NUM_RAILS; i++) begin
                op_freq_q[i] <= freq_default(i);
            end
        end else if (load_pend_q) begin
            op_ccm_q  <= nv_ccm_q;
            op_freq_q <= nv_freq_q;
        end
    end

    // =========================================================
    // Effective per-rail settings
    always_comb begin
        for (int i = 0; i < NUM_RAILS; i++) begin
            slave_on[i]  = (i % 2 == 1) && share_detect[i / 2];
            eff_start[i] = rank_q[slave_on[i] ? i - 1 : i][1 + START_LSB:START_LSB];
            eff_stop[i]  = rank_q[slave_on[i] ? i - 1 : i][1 + STOP_LSB:STOP_LSB];
            eff_freq[i]  = op_freq_q[slave_on[i] ? i - 1 : i];
            eff_ccm[i]   = op_ccm_q[slave_on[i] ? i - 1 : i];
        end
    end

    assign continuous_conduction_select = eff_ccm;

    // =========================================================
    // Read port
    always_comb begin
        rdata_d = RDATA_RST;
        if (page_valid || cmd_code == CMD_GATING) begin
            case (cmd_code)
                CMD_GATING: rdata_d[GATE_BIT] = prior_rail_good_gate_q;
                CMD_RANK: rdata_d[3:0] = rank_q[cmd_page];
                CMD_MODE: begin
                    rdata_d[CCM_BIT]   = ccm_img_q[cmd_page];
                    rdata_d[SHARE_BIT] = !cmd_page[0] && share_detect[cmd_page[1]];
                end
                CMD_FREQ: rdata_d[6:0] = freq_img_q[cmd_page];
                default: rdata_d = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_rdata <= RDATA_RST;
        end else if (cmd_rd) begin
            cmd_rdata <= rdata_d;
        end
    end

    // =========================================================
    // Sequencer
    rail_rank_sequencer u_seq (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .enable      (first_rail_enable_pin),
        .gate_ignore (prior_rail_good_gate_q),
        .start_rank  (eff_start),
        .stop_rank   (eff_stop),
        .power_good  (rail_power_good),
        .rail_on     (rail_on),
        .busy        (seq_busy)
    );

    // =========================================================
    // Switching clocks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quarter_q <= 5'h00;
        end else begin
            quarter_q <= quarter_q + 5'h01;
        end
    end

    for (genvar g = 0; g < NUM_RAILS; g++) begin : g_phase
        rail_phase_gen u_phase (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .quarter_cnt (quarter_q),
            .div         (eff_freq[g][1 + DIV_LSB:DIV_LSB]),
            .phase       (eff_freq[g][4 + PHASE_LSB:PHASE_LSB]),
            .slave       (slave_on[g]),
            .pwm_clk     (pwm_clk[g])
        );
    end

    // =========================================================
    // Checks
    a_op_mode_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(load_pend_q) |-> (op_ccm_q == $past(op_ccm_q) && op_freq_q == $past(op_freq_q)))
        else $error("operating mode changed without reload");

    a_slave_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_wr && page_slave && cmd_code == CMD_RANK) |=> (rank_q == $past(rank_q)))
        else $error("slave page accepted a write");

    a_share_flag_read: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_rd && cmd_code == CMD_MODE && !cmd_page[0])
        |=> (cmd_rdata[SHARE_BIT] == $past(share_detect[cmd_page[1]])))
        else $error("shared flag wrong on master page");

    a_gating_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_rd && cmd_code == CMD_GATING) |=> (cmd_rdata[7:1] == 7'h00))
        else $error("gating reserved bits nonzero");

    a_slave_antiphase: assert property (@(posedge sys_clk) disable iff (rst)
        (share_detect[0] && $stable(share_detect[0]) && $stable(op_freq_q[0]))
        |=> (pwm_clk[1] != pwm_clk[0]))
        else $error("slave not in antiphase");
endmodule

// [rail_seq_pkg.sv]
// Constants shared by the rail sequencing and phase configuration block.
// Assumes a single 50 MHz system clock; one clock is one quarter oscillator period.
package rail_seq_pkg;
    // =========================================================
    // Command codes
    localparam logic [7:0] CMD_GATING     = 8'hd4;
    localparam logic [7:0] CMD_RANK       = 8'hd5;
    localparam logic [7:0] CMD_MODE       = 8'hd6;
    localparam logic [7:0] CMD_FREQ       = 8'hd7;
    // =========================================================
    // Field layout
    localparam int         GATE_BIT       = 0;
    localparam int         START_LSB      = 0;
    localparam int         STOP_LSB       = 2;
    localparam int         CCM_BIT        = 0;
    localparam int         SHARE_BIT      = 1;
    localparam int         DIV_LSB        = 0;
    localparam int         PHASE_LSB      = 2;
    localparam int         RANK_W         = 2;
    localparam int         DIV_W          = 2;
    localparam int         PHASE_W        = 5;
    // =========================================================
    // Reset values
    localparam logic       GATE_RST       = 1'b0;
    localparam logic [1:0] RANK_RST       = 2'h0;
    localparam logic       CCM_RST        = 1'b1;
    localparam logic [1:0] DIV_RST        = 2'h0;
    localparam logic [4:0] PHASE_RST [4]  = '{5'h00, 5'h02, 5'h01, 5'h03};
    localparam logic [7:0] RDATA_RST      = 8'h00;
    // =========================================================
    // Ranks
    localparam logic [1:0] FIRST_RANK     = 2'h0;
    localparam logic [1:0] LAST_RANK      = 2'h3;
    localparam logic [4:0] HALF_BASE      = 5'h02;

    typedef enum logic [1:0] {
        SEQ_OFF   = 2'b00,
        SEQ_START = 2'b01,
        SEQ_ON    = 2'b10,
        SEQ_STOP  = 2'b11
    } seq_state_t;

    // Half a switching period, in quarter oscillator periods
    function automatic logic [4:0] half_period(input logic [1:0] div);
        half_period = HALF_BASE << div;
    endfunction
endpackage

// [rail_rank_sequencer.sv]
// Start and stop sequencer stepping four rails through their ranks.
// Assumes enable and power-good inputs are synchronous to sys_clk.
`timescale 1ns/1ns
module rail_rank_sequencer
    import rail_seq_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            enable,
    input  wire logic            gate_ignore,
    input  wire logic [3:0][1:0] start_rank,
    input  wire logic [3:0][1:0] stop_rank,
    input  wire logic [3:0]      power_good,
    output logic      [3:0]      rail_on,
    output logic                 busy
);
    function automatic logic [3:0] rank_match(input logic [3:0][1:0] r,
                                              input logic [1:0] k);
        rank_match = 4'h0;
        for (int i = 0; i < 4; i++) begin
            rank_match[i] = (r[i] == k);
        end
    endfunction

    seq_state_t state_q;
    logic [1:0] cnt_q;
    logic [3:0] start_m;
    logic [3:0] prev_m;
    logic [3:0] stop_m;
    logic       prev_good;
    logic       advance;

    assign start_m   = rank_match(start_rank, cnt_q);
    assign prev_m    = rank_match(start_rank, cnt_q - 2'h1);
    assign stop_m    = rank_match(stop_rank, cnt_q);
    assign prev_good = &(power_good | ~prev_m);
    assign advance   = (cnt_q == FIRST_RANK) || gate_ignore || prev_good;
    assign busy      = (state_q == SEQ_START) || (state_q == SEQ_STOP);

    // =========================================================
    // Sequence state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= SEQ_OFF;
            cnt_q   <= FIRST_RANK;
        end else begin
            case (state_q)
                SEQ_OFF: begin
                    if (enable) begin
                        state_q <= SEQ_START;
                        cnt_q   <= FIRST_RANK;
                    end
                end
                SEQ_START: begin
                    if (!enable) begin
                        state_q <= SEQ_STOP;
                        cnt_q   <= FIRST_RANK;
                    end else if (advance) begin
                        if (cnt_q == LAST_RANK) begin
                            state_q <= SEQ_ON;
                        end else begin
                            cnt_q <= cnt_q + 2'h1;
                        end
                    end
                end
                SEQ_ON: begin
                    if (!enable) begin
                        state_q <= SEQ_STOP;
                        cnt_q   <= FIRST_RANK;
                    end
                end
                SEQ_STOP: begin
                    if (cnt_q == LAST_RANK) begin
                        state_q <= SEQ_OFF;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                default: begin
                    state_q <= SEQ_OFF;
                end
            endcase
        end
    end

    // =========================================================
    // Rail outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rail_on <= 4'h0;
        end else if (state_q == SEQ_START && enable && advance) begin
            rail_on <= rail_on | start_m;
        end else if (state_q == SEQ_STOP) begin
            rail_on <= rail_on & ~stop_m;
        end
    end

    // =========================================================
    // Checks
    sequence s_start_step;
        state_q == SEQ_START && enable;
    endsequence

    a_first_rank_free: assert property (@(posedge sys_clk) disable iff (rst)
        (s_start_step and (cnt_q == FIRST_RANK)) |=> ((rail_on & $past(start_m)) == $past(start_m)))
        else $error("first rank not started");

    a_gate_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (s_start_step and (!gate_ignore && cnt_q != FIRST_RANK && !prev_good))
        |=> (cnt_q == $past(cnt_q) && rail_on == $past(rail_on)))
        else $error("gated rank advanced without power good");

    a_stop_abort: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == SEQ_START && !enable) |=> (state_q == SEQ_STOP))
        else $error("stop not begun on early deassertion");

    a_stop_rank_off: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == SEQ_STOP) |=> ((rail_on & $past(stop_m)) == 4'h0))
        else $error("stop rank still on");
endmodule

// [rail_phase_gen.sv]
// Switching clock of one rail: divided oscillator, delayed in quarter periods.
// Assumes a shared free-running quarter counter from the parent.
`timescale 1ns/1ns
module rail_phase_gen
    import rail_seq_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [4:0]   quarter_cnt,
    input  wire logic [1:0]   div,
    input  wire logic [4:0]   phase,
    input  wire logic         slave,
    output logic              pwm_clk
);
    logic [4:0] eff_n;
    logic [4:0] pos;
    logic [2:0] bit_sel;

    assign eff_n   = slave ? phase + half_period(div) : phase;
    assign pos     = quarter_cnt - eff_n;
    assign bit_sel = 3'(div) + 3'h1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwm_clk <= 1'b0;
        end else begin
            pwm_clk <= ~pos[bit_sel];
        end
    end

    a_phase_align: assert property (@(posedge sys_clk) disable iff (rst)
        (quarter_cnt == eff_n) |=> pwm_clk)
        else $error("pwm edge not at phase delay");
endmodule

// [rail_load_model.sv]
// Stand-in for the four power stages behind the sequencer.
// Assumes rail_on and hold are synchronous to sys_clk.
`timescale 1ns/1ns
module rail_load_model #(
    parameter int DELAY = 4
)(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] rail_on,
    input  wire logic [3:0] hold,
    output logic      [3:0] power_good
);
    // =========================================================
    // Ramp counters
    int cnt [4];

    // Good only after DELAY clocks on; hold keeps a rail not good
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt        <= '{default: 0};
            power_good <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!rail_on[i]) begin
                    cnt[i]        <= 0;
                    power_good[i] <= 1'b0;
                end else begin
                    if (cnt[i] < DELAY) begin
                        cnt[i] <= cnt[i] + 1;
                    end
                    power_good[i] <= (cnt[i] >= DELAY) && !hold[i];
                end
            end
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the rail sequencing and phase block.
// Assumes the package constants and a 50 MHz sys_clk.
`timescale 1ns/1ns
module tb
    import rail_seq_pkg::*;
;
    logic       sys_clk;
    logic       rst;
    logic       nv_rst;
    logic       nv_store;
    logic       cmd_wr;
    logic       cmd_rd;
    logic [7:0] cmd_code;
    logic [1:0] cmd_page;
    logic [7:0] cmd_wdata;
    logic [7:0] cmd_rdata;
    logic       en;
    logic [3:0] pg;
    logic [3:0] hold;
    logic [1:0] share;
    logic [3:0] rail_on;
    logic [3:0] ccs;
    logic [3:0] pwm_clk;
    logic       seq_busy;
    int         bad_count;
    int         compares;
    int         t [4];
    logic [7:0] rk [4] = '{8'h03, 8'h0c, 8'h09, 8'h01};
    logic [7:0] ph [4] = '{8'h00, 8'h08, 8'h04, 8'h0c};

    rail_sequencing_phase_config rail_sequencing_phase_config_i (
        .sys_clk(sys_clk), .rst(rst), .nv_rst(nv_rst), .nv_store(nv_store),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_page(cmd_page),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .first_rail_enable_pin(en),
        .rail_power_good(pg), .share_detect(share), .rail_on(rail_on),
        .continuous_conduction_select(ccs), .pwm_clk(pwm_clk), .seq_busy(seq_busy)
    );

    rail_load_model rail_load_model_i (
        .sys_clk(sys_clk), .rst(rst), .rail_on(rail_on), .hold(hold), .power_good(pg)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // =========================================================
    // Access and check tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [1:0] page, input logic [7:0] data);
        cmd_code = code;
        cmd_page = page;
        cmd_wdata = data;
        cmd_wr = 1'b1;
        tick(1);
        cmd_wr = 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] code, input logic [1:0] page,
                          input logic [7:0] exp);
        cmd_code = code;
        cmd_page = page;
        cmd_rd = 1'b1;
        tick(1);
        cmd_rd = 1'b0;
        tick(1);
        check(what, cmd_rdata, exp);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(2);
    endtask

    // Cycle at which each rail first reaches lvl
    task automatic edge_times(input logic lvl);
        t = '{default: -1};
        for (int n = 0; n < 40; n++) begin
            tick(1);
            for (int i = 0; i < 4; i++) begin
                if (t[i] < 0 && rail_on[i] === lvl) t[i] = n;
            end
        end
    endtask

    // Rail b lags rail a by d clocks; rail a has period per, 50% duty
    task automatic pwm_lag(input int a, input int b, input int d, input int per);
        logic [3:0] s [80];
        logic       ok;
        ok = 1'b1;
        for (int n = 0; n < 80; n++) begin
            tick(1);
            s[n] = pwm_clk;
        end
        for (int n = d; n < 80; n++) if (s[n][b] !== s[n-d][a]) ok = 1'b0;
        for (int n = per; n < 80; n++) if (s[n][a] !== s[n-per][a]) ok = 1'b0;
        for (int n = per / 2; n < 80; n++) if (s[n][a] === s[n-per/2][a]) ok = 1'b0;
        check("pwm lag", ok, 1'b1);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    // =========================================================
    // Scenarios
    initial begin
        {nv_store, cmd_wr, cmd_rd, en} = 4'h0;
        {cmd_code, cmd_wdata, cmd_page, hold, share} = 24'h0;
        rst = 1'b1;
        nv_rst = 1'b1;
        tick(20);
        rst = 1'b0;
        nv_rst = 1'b0;
        tick(2);
        rd_chk("gate", CMD_GATING, 2'h0, 8'h00);
        for (int p = 0; p < 4; p++) rd_chk("rank", CMD_RANK, 2'(p), 8'h00);
        for (int p = 0; p < 4; p++) rd_chk("phase", CMD_FREQ, 2'(p), ph[p]);
        rd_chk("mode", CMD_MODE, 2'h0, 8'h01);
        rd_chk("unknown", 8'hd8, 2'h0, 8'h00);
        wr(CMD_GATING, 2'h0, 8'hff);
        rd_chk("gate", CMD_GATING, 2'h3, 8'h01);
        wr(CMD_RANK, 2'h0, 8'hff);
        rd_chk("rank", CMD_RANK, 2'h0, 8'h0f);
        wr(CMD_RANK, 2'h0, 8'h00);
        wr(CMD_GATING, 2'h0, 8'h00);
        en = 1'b1;
        edge_times(1'b1);
        check("equal", {t[0] == t[1], t[0] == t[2], t[0] == t[3], t[0] >= 0}, 8'h0f);
        en = 1'b0;
        edge_times(1'b0);
        for (int p = 0; p < 4; p++) wr(CMD_RANK, 2'(p), rk[p]);
        for (int p = 0; p < 4; p++) rd_chk("rank", CMD_RANK, 2'(p), rk[p]);
        wr(CMD_GATING, 2'h0, 8'h01);
        en = 1'b1;
        edge_times(1'b1);
        check("start", {t[2] - t[1] == 1, t[3] == t[2], t[0] - t[1] == 3, t[1] >= 0}, 8'h0f);
        en = 1'b0;
        edge_times(1'b0);
        check("stop", {t[3] == t[0], t[2] - t[0] == 2, t[1] - t[0] == 3, t[0] >= 0}, 8'h0f);
        wr(CMD_GATING, 2'h0, 8'h00);
        hold = 4'b0010;
        en = 1'b1;
        tick(12);
        check("gated", {seq_busy, rail_on}, 8'h12);
        hold = 4'h0;
        edge_times(1'b1);
        check("release", {t[2] == t[3], t[2] >= 0, t[0] - t[2] > 2}, 8'h07);
        en = 1'b0;
        tick(8);
        hold = 4'b0010;
        en = 1'b1;
        tick(8);
        en = 1'b0;
        tick(8);
        check("abort", {seq_busy, rail_on}, 8'h00);
        hold = 4'h0;
        wr(CMD_MODE, 2'h0, 8'hff);
        rd_chk("mode", CMD_MODE, 2'h0, 8'h01);
        wr(CMD_MODE, 2'h0, 8'h00);
        rd_chk("mode", CMD_MODE, 2'h0, 8'h00);
        wr(CMD_FREQ, 2'h0, 8'h04);
        wr(CMD_FREQ, 2'h2, 8'h03);
        wr(CMD_FREQ, 2'h3, 8'h17);
        nv_store = 1'b1;
        tick(1);
        nv_store = 1'b0;
        tick(1);
        check("ccs", ccs, 8'h0f);
        pwm_lag(0, 1, 2, 4);
        do_reset();
        check("ccs", ccs, 8'h0e);
        rd_chk("freq", CMD_FREQ, 2'h3, 8'h17);
        pwm_lag(2, 3, 5, 32);
        pwm_lag(0, 1, 1, 4);
        share = 2'b01;
        do_reset();
        rd_chk("share", CMD_MODE, 2'h0, 8'h02);
        rd_chk("slave", CMD_MODE, 2'h1, 8'h00);
        rd_chk("unshared", CMD_MODE, 2'h2, 8'h01);
        pwm_lag(0, 1, 2, 4);
        wr(CMD_RANK, 2'h1, 8'h05);
        share = 2'b10;
        rd_chk("slave rank", CMD_RANK, 2'h1, 8'h00);
        rd_chk("share pair1", CMD_MODE, 2'h2, 8'h03);
        rd_chk("slave pair1", CMD_MODE, 2'h3, 8'h00);
        complete_run();
    end
endmodule
